// ### src/alu_pkg.sv
/*
  Shared constants and types for the add-and-shift datapath: register
  offsets on the AHB-Lite slave, reset values, flag and command layouts.
  Assumes a 32-bit AHB-Lite fabric decoding this block's window by hsel.
*/
package alu_pkg;

  // byte offsets on the register bus (low address byte)
  localparam logic [7:0] CMD_OFS   = 8'h00;
  localparam logic [7:0] ACC_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] PTR0_OFS  = 8'h0c;
  localparam logic [7:0] PTR1_OFS  = 8'h10;
  localparam logic [7:0] FADDR_OFS = 8'h14;
  localparam logic [7:0] FDATA_OFS = 8'h18;

  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [2:0]  STAT_RST  = 3'h0;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [6:0]  FADDR_RST = 7'h00;
  localparam int          FILE_DEPTH = 128;

  typedef enum logic [2:0] {
    OP_NONE              = 3'b000,
    literal_add_op       = 3'b001,
    literal_and_op       = 3'b010,
    register_add_op      = 3'b011,
    register_and_op      = 3'b100,
    arith_right_shift_op = 3'b101,
    add_with_carry_op    = 3'b110,
    pointer_literal_add  = 3'b111
  } op_t;

  // status register: bit 0 carry, bit 1 half-byte flag, bit 2 zero
  typedef struct packed {
    logic zero;
    logic half_byte_flag;
    logic carry;
  } flags_t;

  // command word written to CMD_OFS
  typedef struct packed {
    logic [7:0] rsv_hi;
    logic [7:0] literal;
    logic       rsv_mid;
    logic [6:0] addr;
    logic [2:0] rsv_lo;
    logic       ptr_sel;
    logic       dest;
    op_t        op;
  } cmd_t;

endpackage : alu_pkg

// ### src/alu_datapath.sv
/*
  Add-and-shift datapath with accumulator, two 16-bit indirect pointers,
  carry/half-byte/zero flags and a 128-byte data register file, reached
  over an AHB-Lite slave. A write to the command register executes one
  operation at the end of that write's data phase.
  Assumes single word transfers and one master; zero wait states.
*/
`timescale 1ns/1ps

// Summary of operation
// RULE_01: pointer add: signed 6-bit literal, flags untouched
// RULE_02: pointer sum wraps modulo 16 bits
// RULE_03: literal AND into accumulator, zero only
// RULE_04: literal add into accumulator, all flags
// RULE_05: register AND with accumulator, zero only
// RULE_06: dest bit: 0 accumulator, 1 register
// RULE_07: register add, all flags, routed result
// RULE_08: arithmetic shift right, bit0 to carry
// RULE_09: add with carry, all flags, routed
// RULE_10: zero, half-byte carry, carry definitions
module alu_datapath (
  input  wire logic        clk_sys,   // 50 MHz system clock
  input  wire logic        resetn,    // synchronous reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // transfer size, word expected
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic             hreadyout, // slave ready
  output logic             hresp,     // response, always okay
  output logic [31:0]      hrdata     // read data
);

  logic [7:0]           acc_r;
  logic [7:0]           acc_nxt;
  alu_pkg::flags_t      flags_r;
  alu_pkg::flags_t      flags_nxt;
  logic [15:0]          ptr0_r;
  logic [15:0]          ptr0_nxt;
  logic [15:0]          ptr1_r;
  logic [15:0]          ptr1_nxt;
  logic [6:0]           faddr_r;
  logic [6:0]           faddr_nxt;
  logic                 wr_pend_r;
  logic                 wr_pend_nxt;
  logic [7:0]           wr_ofs_r;
  logic [7:0]           wr_ofs_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  logic [7:0]           mem_r [alu_pkg::FILE_DEPTH];
  logic                 mem_we;
  logic [6:0]           mem_wa;
  logic [7:0]           mem_wd;
  logic                 addr_ph;
  logic                 exec;
  alu_pkg::cmd_t        cmd;
  logic [7:0]           file_rd;
  logic [7:0]           opnd;
  logic                 cin;
  logic [9:0]           sum;
  logic [7:0]           res;
  logic                 reg_op;
  logic [15:0]          k_ext;

  // returns {carry out of bit 7, carry out of bit 3, 8-bit sum}
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    return {full[8], lo[4], full[7:0]};
  endfunction : add8

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  assign addr_ph = hsel && htrans[1] && hready;
  assign exec    = wr_pend_r && (wr_ofs_r == alu_pkg::CMD_OFS);
  assign cmd     = alu_pkg::cmd_t'(hwdata);
  assign file_rd = mem_r[cmd.addr];
  assign reg_op  = (cmd.op == alu_pkg::register_add_op)
                || (cmd.op == alu_pkg::register_and_op)
                || (cmd.op == alu_pkg::arith_right_shift_op)
                || (cmd.op == alu_pkg::add_with_carry_op);
  assign k_ext   = {{10{cmd.literal[5]}}, cmd.literal[5:0]}; // [RULE_01]

  // operand and adder shared by all 8-bit adding operations
  always_comb
  begin
    opnd = (cmd.op == alu_pkg::literal_add_op) ? cmd.literal : file_rd;
    cin  = (cmd.op == alu_pkg::add_with_carry_op) && flags_r.carry;
    sum  = add8(acc_r, opnd, cin); // [RULE_10]
  end

  // bus side: capture the address phase, register read data early
  always_comb
  begin
    wr_pend_nxt = addr_ph && hwrite;
    wr_ofs_nxt  = addr_ph ? haddr[7:0] : wr_ofs_r;
    rdata_nxt   = 32'h0000_0000;
    if (addr_ph && !hwrite)
    begin
      case (haddr[7:0])
        alu_pkg::ACC_OFS:   rdata_nxt = {24'h00_0000, acc_r};
        alu_pkg::STAT_OFS:  rdata_nxt = {29'h0000_0000, flags_r};
        alu_pkg::PTR0_OFS:  rdata_nxt = {16'h0000, ptr0_r};
        alu_pkg::PTR1_OFS:  rdata_nxt = {16'h0000, ptr1_r};
        alu_pkg::FADDR_OFS: rdata_nxt = {25'h000_0000, faddr_r};
        alu_pkg::FDATA_OFS: rdata_nxt = {24'h00_0000, mem_r[faddr_r]};
        default:            rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // datapath and software writes; the two never share a cycle
  always_comb
  begin
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    ptr0_nxt  = ptr0_r;
    ptr1_nxt  = ptr1_r;
    faddr_nxt = faddr_r;
    mem_we    = 1'b0;
    mem_wa    = cmd.addr;
    mem_wd    = 8'h00;
    res       = 8'h00;
    if (exec)
    begin
      case (cmd.op)
        alu_pkg::literal_add_op:
        begin
          acc_nxt   = sum[7:0]; // [RULE_04]
          flags_nxt = {sum[7:0] == 8'h00, sum[8], sum[9]}; // [RULE_10]
        end
        alu_pkg::literal_and_op:
        begin
          acc_nxt        = acc_r & cmd.literal; // [RULE_03]
          flags_nxt.zero = (acc_nxt == 8'h00);
        end
        alu_pkg::register_add_op, alu_pkg::add_with_carry_op:
        begin
          res       = sum[7:0]; // [RULE_07] [RULE_09]
          flags_nxt = {sum[7:0] == 8'h00, sum[8], sum[9]}; // [RULE_10]
        end
        alu_pkg::register_and_op:
        begin
          res            = acc_r & file_rd; // [RULE_05]
          flags_nxt.zero = (res == 8'h00);
        end
        alu_pkg::arith_right_shift_op:
        begin
          res             = {file_rd[7], file_rd[7:1]}; // [RULE_08]
          flags_nxt.carry = file_rd[0];
          flags_nxt.zero  = (res == 8'h00);
        end
        alu_pkg::pointer_literal_add:
        begin
          // plain 16-bit add wraps both ways at the range ends
          if (cmd.ptr_sel)
            ptr1_nxt = ptr1_r + k_ext; // [RULE_01] [RULE_02]
          else
            ptr0_nxt = ptr0_r + k_ext; // [RULE_01] [RULE_02]
        end
        default:
        begin
          res = 8'h00;
        end
      endcase
      if (reg_op)
      begin
        if (cmd.dest)
        begin
          mem_we = 1'b1; // [RULE_06]
          mem_wd = res;
        end
        else
        begin
          acc_nxt = res; // [RULE_06]
        end
      end
    end
    else if (wr_pend_r)
    begin
      case (wr_ofs_r)
        alu_pkg::ACC_OFS:   acc_nxt   = hwdata[7:0];
        alu_pkg::STAT_OFS:  flags_nxt = alu_pkg::flags_t'(hwdata[2:0]);
        alu_pkg::PTR0_OFS:  ptr0_nxt  = hwdata[15:0];
        alu_pkg::PTR1_OFS:  ptr1_nxt  = hwdata[15:0];
        alu_pkg::FADDR_OFS: faddr_nxt = hwdata[6:0];
        alu_pkg::FDATA_OFS:
        begin
          mem_we = 1'b1;
          mem_wa = faddr_r;
          mem_wd = hwdata[7:0];
        end
        default:
        begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      acc_r     <= alu_pkg::ACC_RST;
      flags_r   <= alu_pkg::flags_t'(alu_pkg::STAT_RST);
      ptr0_r    <= alu_pkg::PTR_RST;
      ptr1_r    <= alu_pkg::PTR_RST;
      faddr_r   <= alu_pkg::FADDR_RST;
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      acc_r     <= acc_nxt;
      flags_r   <= flags_nxt;
      ptr0_r    <= ptr0_nxt;
      ptr1_r    <= ptr1_nxt;
      faddr_r   <= faddr_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_ofs_r  <= wr_ofs_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // data file is storage only; left unreset to keep it a plain RAM
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      mem_r[mem_wa] <= mem_wd;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  ptr_add_a: assert property ( // [RULE_01]
    exec && cmd.op == alu_pkg::pointer_literal_add
    |=> $stable(flags_r) && $stable(acc_r)
        && (ptr0_r == ($past(cmd.ptr_sel) ? $past(ptr0_r)
                       : 16'($past(ptr0_r) + $past(k_ext))))
        && (ptr1_r == (!$past(cmd.ptr_sel) ? $past(ptr1_r)
                       : 16'($past(ptr1_r) + $past(k_ext)))))
    else $error("pointer add gave wrong value or touched flags");

  ptr_wrap_a: assert property ( // [RULE_02]
    exec && cmd.op == alu_pkg::pointer_literal_add && !cmd.ptr_sel
    && ptr0_r == 16'h0000 && cmd.literal[5]
    |=> ptr0_r[15:6] == 10'h3ff)
    else $error("pointer did not wrap below zero to the top");

  lit_and_a: assert property ( // [RULE_03]
    exec && cmd.op == alu_pkg::literal_and_op
    |=> acc_r == $past(acc_r & cmd.literal)
        && flags_r.zero == (acc_r == 8'h00)
        && flags_r.carry == $past(flags_r.carry)
        && flags_r.half_byte_flag == $past(flags_r.half_byte_flag))
    else $error("literal and result or flags wrong");

  lit_add_a: assert property ( // [RULE_04]
    exec && cmd.op == alu_pkg::literal_add_op
    |=> {flags_r.carry, acc_r} == $past({1'b0, acc_r} + {1'b0, cmd.literal})
        && flags_r.zero == (acc_r == 8'h00))
    else $error("literal add result or carry wrong");

  reg_and_a: assert property ( // [RULE_05]
    exec && cmd.op == alu_pkg::register_and_op
    |=> flags_r.zero == ($past(acc_r & file_rd) == 8'h00)
        && $stable(flags_r.carry) && $stable(flags_r.half_byte_flag))
    else $error("register and flags wrong");

  dest_route_a: assert property ( // [RULE_06]
    exec && reg_op
    |=> $past(cmd.dest) ? (mem_r[$past(cmd.addr)] == $past(res)
                           && acc_r == $past(acc_r))
                        : (acc_r == $past(res)
                           && mem_r[$past(cmd.addr)] == $past(file_rd)))
    else $error("result went to the wrong destination");

  reg_add_a: assert property ( // [RULE_07]
    exec && cmd.op == alu_pkg::register_add_op && !cmd.dest
    |=> {flags_r.carry, acc_r} == $past({1'b0, acc_r} + {1'b0, file_rd}))
    else $error("register add sum or carry wrong");

  asr_a: assert property ( // [RULE_08]
    exec && cmd.op == alu_pkg::arith_right_shift_op
    |=> flags_r.carry == $past(file_rd[0])
        && ($past(cmd.dest) ? mem_r[$past(cmd.addr)] : acc_r)
           == {$past(file_rd[7]), $past(file_rd[7:1])})
    else $error("arithmetic shift result or carry wrong");

  adc_a: assert property ( // [RULE_09]
    exec && cmd.op == alu_pkg::add_with_carry_op && cmd.dest
    |=> {flags_r.carry, mem_r[$past(cmd.addr)]}
        == $past({1'b0, acc_r} + {1'b0, file_rd} + {8'h00, flags_r.carry}))
    else $error("add with carry result wrong");

  half_flag_a: assert property ( // [RULE_10]
    exec && cmd.op == alu_pkg::register_add_op
    |=> flags_r.half_byte_flag
        == $past(({1'b0, acc_r[3:0]} + {1'b0, file_rd[3:0]}) > 5'd15))
    else $error("half-byte flag wrong");

  ptr_add_c: cover property (
    exec && cmd.op == alu_pkg::pointer_literal_add && cmd.ptr_sel);
  adc_carry_c: cover property (
    exec && cmd.op == alu_pkg::add_with_carry_op && flags_r.carry);
  file_dest_c: cover property (exec && reg_op && cmd.dest);

endmodule : alu_datapath

// ### bench/ahb_master.sv
/*
  AHB-Lite single-word master standing in for the decoder side.
  Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module ahb_master (
  input  wire logic        clk_sys, // system clock
  input  wire logic        hready,  // bus ready
  input  wire logic [31:0] hrdata,  // read data
  output logic             hsel,    // slave select
  output logic [31:0]      haddr,   // byte address
  output logic [1:0]       htrans,  // transfer type
  output logic             hwrite,  // write when high
  output logic [2:0]       hsize,   // always a word
  output logic [31:0]      hwdata,  // write data
  output logic             to_flag  // a wait ran out
);
  logic [31:0] rd_q;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    to_flag = 1'b0;
  end
  // capture at the edge itself: hrdata falls back to 0 on that edge
  always @(posedge clk_sys)
    rd_q <= hrdata;
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
      to_flag <= 1'b1;
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    #1;
    q = rd_q;
  endtask : xfer
endmodule : ahb_master

// ### bench/testbench.sv
/*
  Self-checking bench for the add-and-shift datapath over AHB-Lite.
  Assumes the register map and command layout of alu_pkg.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [2:0] op;
    logic       dest;
    logic [7:0] lit, acc, fv, st, e_acc, e_fv, e_st;
  } row_t;
  // op, dest, literal, acc, file, status -> acc, file, status
  localparam row_t rows [13] = '{
    '{3'h1, 1'b0, 8'h01, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07},
    '{3'h1, 1'b1, 8'h12, 8'h34, 8'h9e, 8'h07, 8'h46, 8'h9e, 8'h00},
    '{3'h2, 1'b0, 8'h0f, 8'hf0, 8'h00, 8'h03, 8'h00, 8'h00, 8'h07},
    '{3'h2, 1'b0, 8'hff, 8'h5a, 8'h00, 8'h07, 8'h5a, 8'h00, 8'h03},
    '{3'h3, 1'b0, 8'h00, 8'h08, 8'h08, 8'h00, 8'h10, 8'h08, 8'h02},
    '{3'h3, 1'b1, 8'h00, 8'h80, 8'h80, 8'h00, 8'h80, 8'h00, 8'h05},
    '{3'h4, 1'b0, 8'h00, 8'hcc, 8'haa, 8'h03, 8'h88, 8'haa, 8'h03},
    '{3'h4, 1'b1, 8'h00, 8'h0f, 8'hf0, 8'h00, 8'h0f, 8'h00, 8'h04},
    '{3'h5, 1'b1, 8'h00, 8'h11, 8'h81, 8'h02, 8'h11, 8'hc0, 8'h03},
    '{3'h5, 1'b0, 8'h00, 8'h55, 8'h01, 8'h00, 8'h00, 8'h01, 8'h05},
    '{3'h6, 1'b0, 8'h00, 8'h0f, 8'h00, 8'h01, 8'h10, 8'h00, 8'h02},
    '{3'h6, 1'b1, 8'h00, 8'hff, 8'h00, 8'h01, 8'hff, 8'h00, 8'h07},
    '{3'h0, 1'b0, 8'h00, 8'h3c, 8'h77, 8'h05, 8'h3c, 8'h77, 8'h05}};
  logic        clk_sys;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        to_flag;
  int          bad_count;
  int          total_checks;
  row_t        r;
  alu_datapath alu_datapath_i (.clk_sys(clk_sys), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  ahb_master ahb_master_i (.clk_sys(clk_sys), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .to_flag(to_flag));
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] x8(logic [7:0] v);
    return {24'h00_0000, v};
  endfunction : x8
  function automatic logic [31:0] mk(logic [2:0] op, logic dest,
                                     logic ps, logic [7:0] lit);
    alu_pkg::cmd_t c;
    c = '0;
    c.op = alu_pkg::op_t'(op);
    c.dest = dest;
    c.ptr_sel = ps;
    c.addr = 7'h7f;
    c.literal = lit;
    return c;
  endfunction : mk
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    ahb_master_i.xfer(1'b1, x8(a), d, q);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    logic [31:0] q;
    ahb_master_i.xfer(1'b0, x8(a), 32'h0000_0000, q);
    chk(nm, e, q);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    chk("hreadyout", 32'h0000_0001, {31'h0000_0000, hreadyout});
  endtask : rd
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge to_flag)
  begin
    bad_count++;
    conclude();
  end
  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(alu_pkg::ACC_OFS, x8(alu_pkg::ACC_RST), "acc rst");
    rd(alu_pkg::STAT_OFS, x8({5'h00, alu_pkg::STAT_RST}), "stat rst");
    rd(alu_pkg::PTR0_OFS, {16'h0000, alu_pkg::PTR_RST}, "ptr0 rst");
    rd(alu_pkg::FADDR_OFS, x8({1'b0, alu_pkg::FADDR_RST}), "faddr rst");
    rd(alu_pkg::CMD_OFS, 32'h0000_0000, "cmd read");
    wr(8'h1c, 32'h0000_00a5);
    rd(8'h1c, 32'h0000_0000, "unmapped");
    wr(alu_pkg::FADDR_OFS, 32'h0000_007f);
    foreach (rows[i])
    begin
      r = rows[i];
      wr(alu_pkg::FDATA_OFS, x8(r.fv));
      wr(alu_pkg::ACC_OFS, x8(r.acc));
      wr(alu_pkg::STAT_OFS, x8(r.st));
      wr(alu_pkg::CMD_OFS, mk(r.op, r.dest, 1'b0, r.lit));
      rd(alu_pkg::ACC_OFS, x8(r.e_acc), "acc");
      rd(alu_pkg::FDATA_OFS, x8(r.e_fv), "file");
      rd(alu_pkg::STAT_OFS, x8(r.e_st), "stat");
    end
    // pointer add: wrap both ways, extreme literals, flags untouched
    wr(alu_pkg::STAT_OFS, x8(8'h05));
    wr(alu_pkg::PTR0_OFS, 32'h0000_ffff);
    wr(alu_pkg::PTR1_OFS, 32'h0000_0000);
    wr(alu_pkg::CMD_OFS, mk(3'h7, 1'b0, 1'b0, 8'h01));
    rd(alu_pkg::PTR0_OFS, 32'h0000_0000, "ptr0 up");
    wr(alu_pkg::CMD_OFS, mk(3'h7, 1'b0, 1'b1, 8'h20));
    rd(alu_pkg::PTR1_OFS, 32'h0000_ffe0, "ptr1 down");
    wr(alu_pkg::CMD_OFS, mk(3'h7, 1'b0, 1'b0, 8'h1f));
    rd(alu_pkg::PTR0_OFS, 32'h0000_001f, "ptr0 k31");
    rd(alu_pkg::PTR1_OFS, 32'h0000_ffe0, "ptr1 kept");
    // pointer 0 stepped below zero by k = -1 must land on the top
    wr(alu_pkg::PTR0_OFS, 32'h0000_0000);
    wr(alu_pkg::CMD_OFS, mk(3'h7, 1'b0, 1'b0, 8'h3f));
    rd(alu_pkg::PTR0_OFS, 32'h0000_ffff, "ptr0 down");
    rd(alu_pkg::STAT_OFS, x8(8'h05), "ptr flags");
    // second reset in mid-run
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(alu_pkg::PTR1_OFS, {16'h0000, alu_pkg::PTR_RST}, "ptr1 rst2");
    rd(alu_pkg::STAT_OFS, x8({5'h00, alu_pkg::STAT_RST}), "stat rst2");
    conclude();
  end
endmodule : testbench
